// [addr_gen_pkg.sv]
// Purpose: shared constants, enums and carriers for cpu address generation
// Assumes: 16-bit logical space, 18-bit (256 KB) physical code space
// Notes: bank window decode lives in bank_map
package addr_gen_pkg;

    // ----------------------------------------
    // widths and map
    // ----------------------------------------
    localparam int REGS_W = 256;
    localparam logic [15:0] COMMON_TOP = 16'h7FFF;
    localparam logic [15:0] BANK_WIN_LO = 16'h8000;
    localparam logic [15:0] BANK_WIN_HI = 16'hBFFF;
    localparam logic [1:0] PHYS_HIGH_TAG = 2'h2;
    localparam logic [2:0] BANK_RESET = 3'h0;
    localparam logic [4:0] FIXED_CALL_TAG = 5'h01;
    localparam logic [15:0] FIXED_CALL_LO = 16'h0800;
    localparam logic [15:0] FIXED_CALL_HI = 16'h0FFF;
    localparam logic [9:0] VEC_TABLE_TAG = 10'h001;
    localparam logic [15:0] VEC_TABLE_LO = 16'h0040;
    localparam logic [15:0] VEC_TABLE_HI = 16'h007F;
    localparam logic [6:0] SADDR_TAG = 7'h7F;
    localparam logic [7:0] SADDR_BIT8_LIMIT = 8'h20;
    localparam logic [15:0] SADDR_LO = 16'hFE20;
    localparam logic [15:0] SADDR_HI = 16'hFF1F;
    localparam logic [7:0] SFR_PAGE = 8'hFF;
    localparam logic [7:0] SFR_GAP_LO = 8'hD0;
    localparam logic [7:0] SFR_GAP_HI = 8'hDF;
    localparam logic [15:0] HS_RAM_TOP = 16'hFEFF;

    // ----------------------------------------
    // register codes
    // ----------------------------------------
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;
    localparam logic [1:0] PAIR_AX = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h2;
    localparam logic [1:0] PAIR_HL = 2'h3;

    // ----------------------------------------
    // modes and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        BR_NONE = 3'b000,
        BR_REL = 3'b001,
        BR_ABS = 3'b010,
        BR_FIXED = 3'b011,
        BR_TABLE = 3'b100,
        BR_REG = 3'b101
    } branch_kind_e;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_IMPLIED = 4'b0001,
        OP_REG = 4'b0010,
        OP_REGPAIR = 4'b0011,
        OP_DIRECT = 4'b0100,
        OP_SADDR = 4'b0101,
        OP_SFR = 4'b0110,
        OP_INDIRECT = 4'b0111,
        OP_BASED = 4'b1000,
        OP_BASED_IDX = 4'b1001,
        OP_STACK = 4'b1010
    } operand_mode_e;

    typedef enum logic [2:0] {
        IMP_UNSIGNED_MULTIPLY = 3'b000,
        IMP_UNSIGNED_WORD_DIVIDE = 3'b001,
        IMP_DECIMAL_ADJUST_ADD = 3'b010,
        IMP_DECIMAL_ADJUST_SUB = 3'b011,
        IMP_DIGIT_ROTATE_RIGHT = 3'b100,
        IMP_DIGIT_ROTATE_LEFT = 3'b101
    } implied_op_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_VEC_WAIT = 1'b1
    } gen_state_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] instrLen;
        branch_kind_e branchKind;
        operand_mode_e opMode;
        implied_op_e impOp;
        logic [15:0] imm16;
        logic [7:0] branchDisplacement;
        logic [2:0] regCode;
        logic [1:0] pairCode;
        logic indexUseC;
        logic wordAccess;
    } addr_req_s;

    typedef struct packed {
        gen_state_e state;
        logic [15:0] pc;
        logic [2:0] bank;
        logic [17:0] fetchPhys;
        operand_mode_e opMode;
        logic [15:0] opAddr;
        logic [17:0] opPhys;
        logic opIsReg;
        logic [4:0] regTarget;
        logic regIsWord;
        logic done;
        logic vecReq;
        logic [15:0] vecAddr;
        logic sfrFault;
        logic stackFault;
        logic straddleFault;
    } addr_state_s;

endpackage

// [bank_map.sv]
// Purpose: logical to physical address through the bank window
// Assumes: bank value already limited by software to legal banks
// Notes: area above the window gets its own physical tag
`timescale 1ns/1ps
module bank_map (
    input wire logic [15:0] logicalAddr,
    input wire logic [2:0] bankSel,
    output logic [17:0] physAddr
);
    always_comb begin
        if (logicalAddr >= addr_gen_pkg::BANK_WIN_LO && logicalAddr <= addr_gen_pkg::BANK_WIN_HI) begin
            physAddr = 18'(addr_gen_pkg::BANK_WIN_LO) + {1'b0, bankSel, 14'h0000} + {4'h0, logicalAddr[13:0]};
        end else if (logicalAddr > addr_gen_pkg::BANK_WIN_HI) begin
            physAddr = {addr_gen_pkg::PHYS_HIGH_TAG, logicalAddr};
        end else begin
            physAddr = {2'h0, logicalAddr};
        end
    end
endmodule

// [cpu_address_generation.sv]
// Purpose: fetch, branch target and operand address generation
// Assumes: startValid pulses once per instruction, fields decoded
// Notes: table call waits for the vector word before done
`timescale 1ns/1ps
module cpu_address_generation #(
    parameter logic [15:0] HS_RAM_BASE = 16'hFB00
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic startValid,
    input wire addr_gen_pkg::addr_req_s req,
    input wire logic [255:0] regFile,
    input wire logic regBankSelLo,
    input wire logic regBankSelHi,
    input wire logic [15:0] stackPtr,
    input wire logic bankWrite,
    input wire logic [2:0] bankWdata,
    input wire logic [15:0] vecData,
    input wire logic vecValid,
    output logic busy,
    output logic done,
    output logic [15:0] progCounter,
    output logic [2:0] bankSel,
    output logic [17:0] fetchPhys,
    output logic [15:0] opAddr,
    output logic [17:0] opPhys,
    output logic opIsReg,
    output logic [4:0] regTarget,
    output logic regIsWord,
    output logic vecReq,
    output logic [15:0] vecAddr,
    output logic sfrFault,
    output logic stackFault,
    output logic straddleFault
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] addWrap(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0];
    endfunction

    function automatic logic [15:0] signExt(input logic [7:0] d);
        return {{8{d[7]}}, d};
    endfunction

    addr_gen_pkg::addr_state_s cur_q;
    addr_gen_pkg::addr_state_s cur_d;

    logic [1:0] regBank;
    logic [7:0] byteVal;
    logic [15:0] pairVal;
    logic [15:0] axVal;
    logic [15:0] deVal;
    logic [15:0] hlVal;
    logic [7:0] bVal;
    logic [7:0] cVal;
    logic [17:0] nextFetchPhys;
    logic [17:0] nextOpPhys;
    logic [15:0] nextPcSeq;
    logic [15:0] lastByte;
    logic accept;

    // ----------------------------------------
    // register file and bank window
    // ----------------------------------------
    assign regBank = {regBankSelHi, regBankSelLo};
    assign accept = startValid && (cur_q.state == addr_gen_pkg::ST_IDLE);

    reg_bank_read u_regs (
        .regFile(regFile),
        .bankIdx(regBank),
        .byteCode(req.regCode),
        .pairCode(req.pairCode),
        .byteVal(byteVal),
        .pairVal(pairVal),
        .axVal(axVal),
        .deVal(deVal),
        .hlVal(hlVal),
        .bVal(bVal),
        .cVal(cVal)
    );

    // banked fetch resolves only through the bank register
    bank_map u_fetch_map (
        .logicalAddr(cur_d.pc),
        .bankSel(cur_d.bank),
        .physAddr(nextFetchPhys)
    );

    bank_map u_op_map (
        .logicalAddr(cur_d.opAddr),
        .bankSel(cur_d.bank),
        .physAddr(nextOpPhys)
    );

    assign nextPcSeq = addWrap(cur_q.pc, {13'h0000, req.instrLen});
    assign lastByte = addWrap(cur_q.pc, {13'h0000, req.instrLen} - 16'h0001);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        cur_d = cur_q;
        cur_d.done = 1'b0;
        if (bankWrite) begin
            cur_d.bank = bankWdata;
        end
        case (cur_q.state)
            addr_gen_pkg::ST_IDLE: begin
                if (accept) begin
                    // inputs are sampled here, before write-back alters them
                    cur_d.done = 1'b1;
                    cur_d.opMode = req.opMode;
                    cur_d.opIsReg = 1'b0;
                    cur_d.regIsWord = req.wordAccess;
                    cur_d.regTarget = {regBank, req.regCode};
                    cur_d.opAddr = 16'h0000;
                    cur_d.sfrFault = 1'b0;
                    cur_d.stackFault = 1'b0;
                    // only bank 0 continues seamlessly across 7FFFH/8000H
                    cur_d.straddleFault = (cur_q.pc <= addr_gen_pkg::COMMON_TOP)
                        && (lastByte >= addr_gen_pkg::BANK_WIN_LO)
                        && (cur_q.bank != addr_gen_pkg::BANK_RESET);
                    case (req.branchKind)
                        addr_gen_pkg::BR_NONE: begin
                            cur_d.pc = nextPcSeq;
                        end
                        addr_gen_pkg::BR_REL: begin
                            cur_d.pc = addWrap(nextPcSeq, signExt(req.branchDisplacement));
                        end
                        addr_gen_pkg::BR_ABS: begin
                            cur_d.pc = req.imm16;
                        end
                        addr_gen_pkg::BR_FIXED: begin
                            cur_d.pc = {addr_gen_pkg::FIXED_CALL_TAG, req.imm16[10:0]};
                        end
                        addr_gen_pkg::BR_TABLE: begin
                            // word entries: opcode bits 5..1 form the even offset
                            cur_d.done = 1'b0;
                            cur_d.state = addr_gen_pkg::ST_VEC_WAIT;
                            cur_d.vecReq = 1'b1;
                            cur_d.vecAddr = {addr_gen_pkg::VEC_TABLE_TAG, req.opcode[5:1], 1'b0};
                        end
                        addr_gen_pkg::BR_REG: begin
                            cur_d.pc = axVal;
                        end
                        default: begin
                            cur_d.pc = nextPcSeq;
                        end
                    endcase
                    case (req.opMode)
                        addr_gen_pkg::OP_IMPLIED: begin
                            // multiply and divide use the pair, the rest the byte
                            cur_d.opIsReg = 1'b1;
                            if (req.impOp == addr_gen_pkg::IMP_UNSIGNED_MULTIPLY
                                || req.impOp == addr_gen_pkg::IMP_UNSIGNED_WORD_DIVIDE) begin
                                cur_d.regTarget = {regBank, addr_gen_pkg::REG_X};
                                cur_d.regIsWord = 1'b1;
                            end else begin
                                cur_d.regTarget = {regBank, addr_gen_pkg::REG_A};
                                cur_d.regIsWord = 1'b0;
                            end
                        end
                        addr_gen_pkg::OP_REG: begin
                            cur_d.opIsReg = 1'b1;
                            cur_d.regTarget = {regBank, req.regCode};
                            cur_d.regIsWord = 1'b0;
                        end
                        addr_gen_pkg::OP_REGPAIR: begin
                            cur_d.opIsReg = 1'b1;
                            cur_d.regTarget = {regBank, req.pairCode, 1'b0};
                            cur_d.regIsWord = 1'b1;
                        end
                        addr_gen_pkg::OP_DIRECT: begin
                            cur_d.opAddr = req.imm16;
                        end
                        addr_gen_pkg::OP_SADDR: begin
                            // low 20H codes fold up onto the register page
                            cur_d.opAddr = {addr_gen_pkg::SADDR_TAG,
                                req.imm16[7:0] < addr_gen_pkg::SADDR_BIT8_LIMIT, req.imm16[7:0]};
                        end
                        addr_gen_pkg::OP_SFR: begin
                            cur_d.opAddr = {addr_gen_pkg::SFR_PAGE, req.imm16[7:0]};
                            cur_d.sfrFault = (req.imm16[7:0] >= addr_gen_pkg::SFR_GAP_LO
                                && req.imm16[7:0] <= addr_gen_pkg::SFR_GAP_HI)
                                || (req.wordAccess && req.imm16[0]);
                        end
                        addr_gen_pkg::OP_INDIRECT: begin
                            cur_d.opAddr = (req.pairCode == addr_gen_pkg::PAIR_HL) ? hlVal : deVal;
                        end
                        addr_gen_pkg::OP_BASED: begin
                            cur_d.opAddr = addWrap(hlVal, {8'h00, req.imm16[7:0]});
                        end
                        addr_gen_pkg::OP_BASED_IDX: begin
                            cur_d.opAddr = addWrap(hlVal, {8'h00, req.indexUseC ? cVal : bVal});
                        end
                        addr_gen_pkg::OP_STACK: begin
                            cur_d.opAddr = stackPtr;
                            cur_d.stackFault = (stackPtr < HS_RAM_BASE) || (stackPtr > addr_gen_pkg::HS_RAM_TOP);
                        end
                        default: begin
                            cur_d.opAddr = 16'h0000;
                        end
                    endcase
                end
            end
            addr_gen_pkg::ST_VEC_WAIT: begin
                if (vecValid) begin
                    cur_d.pc = vecData;
                    cur_d.vecReq = 1'b0;
                    cur_d.done = 1'b1;
                    cur_d.state = addr_gen_pkg::ST_IDLE;
                end
            end
            default: begin
                cur_d.state = addr_gen_pkg::ST_IDLE;
                cur_d.vecReq = 1'b0;
            end
        endcase
        cur_d.fetchPhys = nextFetchPhys;
        cur_d.opPhys = nextOpPhys;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_q <= '0;
            cur_q.bank <= addr_gen_pkg::BANK_RESET;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign busy = (cur_q.state != addr_gen_pkg::ST_IDLE);
    assign done = cur_q.done;
    assign progCounter = cur_q.pc;
    assign bankSel = cur_q.bank;
    assign fetchPhys = cur_q.fetchPhys;
    assign opAddr = cur_q.opAddr;
    assign opPhys = cur_q.opPhys;
    assign opIsReg = cur_q.opIsReg;
    assign regTarget = cur_q.regTarget;
    assign regIsWord = cur_q.regIsWord;
    assign vecReq = cur_q.vecReq;
    assign vecAddr = cur_q.vecAddr;
    assign sfrFault = cur_q.sfrFault;
    assign stackFault = cur_q.stackFault;
    assign straddleFault = cur_q.straddleFault;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [15:0] chkLen;
    logic [15:0] chkDisp;
    logic [7:0] chkImm8;
    logic [15:0] chkAx;
    logic [15:0] chkHl;
    assign chkLen = {13'h0000, req.instrLen};
    assign chkDisp = signExt(req.branchDisplacement);
    assign chkImm8 = req.imm16[7:0];
    assign chkAx = axVal;
    assign chkHl = hlVal;

    a_seq_advance: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.branchKind == addr_gen_pkg::BR_NONE |=> progCounter == $past(progCounter) + $past(chkLen))
        else $error("pc did not advance by instruction length");

    a_rel_target: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.branchKind == addr_gen_pkg::BR_REL
        |=> progCounter - ($past(progCounter) + $past(chkLen)) == $past(chkDisp))
        else $error("relative target wrong");

    a_fixed_region: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.branchKind == addr_gen_pkg::BR_FIXED
        |=> progCounter >= addr_gen_pkg::FIXED_CALL_LO && progCounter <= addr_gen_pkg::FIXED_CALL_HI)
        else $error("fixed call outside its area");

    a_table_fetch: assert property (@(posedge core_clk) disable iff (!reset_n)
        vecReq |-> vecAddr >= addr_gen_pkg::VEC_TABLE_LO && vecAddr <= addr_gen_pkg::VEC_TABLE_HI
        && !vecAddr[0] && !done)
        else $error("vector address outside table");

    a_table_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        vecReq && vecValid |=> done && !vecReq && progCounter == $past(vecData))
        else $error("vector not loaded into pc");

    a_reg_branch: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.branchKind == addr_gen_pkg::BR_REG |=> progCounter == $past(chkAx))
        else $error("register branch did not load AX");

    a_saddr_window: assert property (@(posedge core_clk) disable iff (!reset_n)
        done && cur_q.opMode == addr_gen_pkg::OP_SADDR
        |-> opAddr >= addr_gen_pkg::SADDR_LO && opAddr <= addr_gen_pkg::SADDR_HI
        && opAddr[8] == (opAddr[7:0] < addr_gen_pkg::SADDR_BIT8_LIMIT))
        else $error("short direct address outside window");

    a_sfr_map: assert property (@(posedge core_clk) disable iff (!reset_n)
        done && cur_q.opMode == addr_gen_pkg::OP_SFR && !sfrFault
        |-> opAddr[15:8] == addr_gen_pkg::SFR_PAGE
        && !(opAddr[7:0] >= addr_gen_pkg::SFR_GAP_LO && opAddr[7:0] <= addr_gen_pkg::SFR_GAP_HI)
        && !(regIsWord && opAddr[0]))
        else $error("special register address not allowed");

    a_based_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.opMode == addr_gen_pkg::OP_BASED |=> opAddr - $past(chkHl) == {8'h00, $past(chkImm8)})
        else $error("based address wrong");

    a_bank_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(reset_n) |-> bankSel == addr_gen_pkg::BANK_RESET)
        else $error("bank not zero after reset");

    a_common_area: assert property (@(posedge core_clk) disable iff (!reset_n)
        progCounter < addr_gen_pkg::BANK_WIN_LO |-> fetchPhys == {2'h0, progCounter})
        else $error("common area fetch went through bank");

    a_abs_target: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.branchKind == addr_gen_pkg::BR_ABS |=> progCounter == $past(req.imm16))
        else $error("absolute target not loaded");

    a_direct_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.opMode == addr_gen_pkg::OP_DIRECT |=> opAddr == $past(req.imm16))
        else $error("direct address wrong");

    a_index_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept && req.opMode == addr_gen_pkg::OP_BASED_IDX
        |=> opAddr - $past(hlVal) == {8'h00, $past(req.indexUseC ? cVal : bVal)})
        else $error("based indexed address wrong");

    a_stack_range: assert property (@(posedge core_clk) disable iff (!reset_n)
        done && cur_q.opMode == addr_gen_pkg::OP_STACK && !stackFault
        |-> opAddr >= HS_RAM_BASE && opAddr <= addr_gen_pkg::HS_RAM_TOP)
        else $error("stack address outside high-speed RAM");

endmodule

// [cpu_address_generation_test.sv]
// Purpose: self-checking bench for cpu address generation
// Assumes: inputs move at the falling edge
// Notes: bank 2 holds the register data used by operand modes
`timescale 1ns/1ps
module cpu_address_generation_test;
    logic core_clk, reset_n, startValid, regBankSelLo, regBankSelHi, bankWrite, vecValid, busy, done;
    logic opIsReg, regIsWord, vecReq, sfrFault, stackFault, straddleFault;
    logic [255:0] regFile;
    logic [15:0] stackPtr, vecData, progCounter, opAddr, vecAddr;
    logic [17:0] fetchPhys, opPhys;
    logic [2:0] bankWdata, bankSel;
    logic [4:0] regTarget;
    logic [3:0] latency;
    addr_gen_pkg::addr_req_s req, r;
    int error_cnt = 0;
    int n_checks = 0;
    cpu_address_generation i_dut (.core_clk(core_clk), .reset_n(reset_n), .startValid(startValid), .req(req),
        .regFile(regFile), .regBankSelLo(regBankSelLo), .regBankSelHi(regBankSelHi), .stackPtr(stackPtr),
        .bankWrite(bankWrite), .bankWdata(bankWdata), .vecData(vecData), .vecValid(vecValid), .busy(busy),
        .done(done), .progCounter(progCounter), .bankSel(bankSel), .fetchPhys(fetchPhys), .opAddr(opAddr),
        .opPhys(opPhys), .opIsReg(opIsReg), .regTarget(regTarget), .regIsWord(regIsWord), .vecReq(vecReq),
        .vecAddr(vecAddr), .sfrFault(sfrFault), .stackFault(stackFault), .straddleFault(straddleFault));
    vec_table_model i_vec (.core_clk(core_clk), .latency(latency), .vecReq(vecReq), .vecAddr(vecAddr),
        .vecData(vecData), .vecValid(vecValid));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [18:0] got, input logic [18:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task issue;
        int n;
        // one idle edge keeps startValid from being lowered and raised in one step
        @(negedge core_clk);
        req = r;
        startValid = 1'b1;
        @(negedge core_clk);
        startValid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        chk(n < 50, 1'b1);
    endtask
    task br(input addr_gen_pkg::branch_kind_e k, input logic [2:0] len, input logic [15:0] imm);
        r = '0;
        r.branchKind = k;
        r.instrLen = len;
        r.imm16 = imm;
        r.branchDisplacement = imm[7:0];
        r.opcode = imm[7:0];
        issue;
    endtask
    task op(input addr_gen_pkg::operand_mode_e m, input logic [15:0] imm, input logic [1:0] sel);
        r = '0;
        r.opMode = m;
        r.imm16 = imm;
        r.regCode = imm[2:0];
        r.impOp = addr_gen_pkg::implied_op_e'(imm[2:0]);
        r.pairCode = sel;
        r.indexUseC = sel[0];
        r.wordAccess = sel[0];
        issue;
    endtask
    task setBank(input logic [2:0] b);
        bankWdata = b;
        bankWrite = 1'b1;
        @(negedge core_clk);
        bankWrite = 1'b0;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_branch;
        br(addr_gen_pkg::BR_NONE, 3'h3, 16'h0000); chk(progCounter, 16'h0003);
        br(addr_gen_pkg::BR_REL, 3'h2, 16'h0080); chk(progCounter, 16'hFF85);
        chk(fetchPhys, 18'h2FF85);
        br(addr_gen_pkg::BR_REL, 3'h2, 16'h007F); chk(progCounter, 16'h0006);
        setBank(3'h3);
        br(addr_gen_pkg::BR_ABS, 3'h3, 16'hBFFF); chk(progCounter, 16'hBFFF);
        chk(fetchPhys, 18'h17FFF);
        br(addr_gen_pkg::BR_FIXED, 3'h3, 16'hFFFF); chk(progCounter, 16'h0FFF);
        br(addr_gen_pkg::BR_REG, 3'h1, 16'h0000); chk(progCounter, 16'hABCD);
        br(addr_gen_pkg::BR_ABS, 3'h3, 16'h7FFF);
        br(addr_gen_pkg::BR_NONE, 3'h2, 16'h0000); chk(straddleFault, 1'b1);
        br(addr_gen_pkg::BR_ABS, 3'h3, 16'h7FFF);
        setBank(3'h0);
        br(addr_gen_pkg::BR_NONE, 3'h2, 16'h0000); chk(straddleFault, 1'b0);
        $display("test branch done");
    endtask
    task t_operand;
        op(addr_gen_pkg::OP_DIRECT, 16'h9ABC, 2'h0); chk(opAddr, 16'h9ABC);
        chk(opPhys, 18'h09ABC);
        op(addr_gen_pkg::OP_SADDR, 16'h001F, 2'h0); chk(opAddr, 16'hFF1F);
        op(addr_gen_pkg::OP_SADDR, 16'h0020, 2'h0); chk(opAddr, 16'hFE20);
        op(addr_gen_pkg::OP_SFR, 16'h00D5, 2'h0); chk(sfrFault, 1'b1);
        op(addr_gen_pkg::OP_SFR, 16'h0021, 2'h1); chk(sfrFault, 1'b1);
        op(addr_gen_pkg::OP_SFR, 16'h0020, 2'h1); chk({opAddr, sfrFault}, 17'h1FE40);
        op(addr_gen_pkg::OP_INDIRECT, 16'h0000, 2'h2); chk(opAddr, 16'h1234);
        op(addr_gen_pkg::OP_INDIRECT, 16'h0000, 2'h3); chk(opAddr, 16'hFFF0);
        op(addr_gen_pkg::OP_BASED, 16'h0030, 2'h0); chk(opAddr, 16'h0020);
        op(addr_gen_pkg::OP_BASED_IDX, 16'h0000, 2'h1); chk(opAddr, 16'h0010);
        op(addr_gen_pkg::OP_BASED_IDX, 16'h0000, 2'h0); chk(opAddr, 16'hFFF5);
        op(addr_gen_pkg::OP_STACK, 16'h0000, 2'h0); chk({opAddr, stackFault}, 17'h1FDFE);
        stackPtr = 16'hFF00;
        op(addr_gen_pkg::OP_STACK, 16'h0000, 2'h0); chk(stackFault, 1'b1);
        for (int i = 0; i < 6; i++) begin
            op(addr_gen_pkg::OP_IMPLIED, 16'(i), 2'h0);
            chk({regTarget, regIsWord}, {2'h2, (i < 2) ? 3'h0 : 3'h1, i < 2});
        end
        op(addr_gen_pkg::OP_REG, 16'h0003, 2'h0); chk({opIsReg, regTarget}, 6'h33);
        $display("test operand done");
    endtask
    task t_table;
        br(addr_gen_pkg::BR_TABLE, 3'h1, 16'h003E); chk(progCounter, 16'h7E5A);
        chk({busy, vecReq, done}, 3'h1);
        latency = 4'h4;
        br(addr_gen_pkg::BR_TABLE, 3'h1, 16'h0000); chk(progCounter, 16'h405A);
        $display("test table done");
    endtask
    task t_reset;
        setBank(3'h5);
        chk(bankSel, 3'h5);
        reset_n = 1'b0;
        @(negedge core_clk);
        chk({bankSel, progCounter}, 19'h0);
        reset_n = 1'b1;
        @(negedge core_clk);
        $display("test reset done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #(8 * 5000);
        error_cnt++;
        end_sim;
    end
    initial begin
        reset_n = 1'b0;
        startValid = 1'b0;
        bankWrite = 1'b0;
        bankWdata = 3'h0;
        latency = 4'h0;
        stackPtr = 16'hFEFF;
        regBankSelLo = 1'b0;
        regBankSelHi = 1'b1;
        regFile = {32{8'h55}};
        regFile[191:128] = 64'hFFF0_1234_0520_ABCD;
        r = '0;
        req = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        t_branch;
        t_operand;
        t_table;
        t_reset;
        end_sim;
    end
endmodule

// [reg_bank_read.sv]
// Purpose: read ports into the four general register banks
// Assumes: bank b byte code r sits at bit (b*8+r)*8
// Notes: pairs are low code even, high code odd
`timescale 1ns/1ps
module reg_bank_read (
    input wire logic [255:0] regFile,
    input wire logic [1:0] bankIdx,
    input wire logic [2:0] byteCode,
    input wire logic [1:0] pairCode,
    output logic [7:0] byteVal,
    output logic [15:0] pairVal,
    output logic [15:0] axVal,
    output logic [15:0] deVal,
    output logic [15:0] hlVal,
    output logic [7:0] bVal,
    output logic [7:0] cVal
);
    function automatic logic [7:0] getByte(input logic [255:0] f, input logic [1:0] b, input logic [2:0] c);
        logic [7:0] base;
        base = {b, c, 3'h0};
        return f[base +: 8];
    endfunction

    function automatic logic [15:0] getPair(input logic [255:0] f, input logic [1:0] b, input logic [1:0] p);
        return {getByte(f, b, {p, 1'b1}), getByte(f, b, {p, 1'b0})};
    endfunction

    always_comb begin
        byteVal = getByte(regFile, bankIdx, byteCode);
        pairVal = getPair(regFile, bankIdx, pairCode);
        axVal = getPair(regFile, bankIdx, addr_gen_pkg::PAIR_AX);
        deVal = getPair(regFile, bankIdx, addr_gen_pkg::PAIR_DE);
        hlVal = getPair(regFile, bankIdx, addr_gen_pkg::PAIR_HL);
        bVal = getByte(regFile, bankIdx, addr_gen_pkg::REG_B);
        cVal = getByte(regFile, bankIdx, addr_gen_pkg::REG_C);
    end
endmodule

// [vec_table_model.sv]
// Purpose: vector table side of the internal memory bus
// Assumes: one word per request, latency set by the bench
// Notes: data lines toggle while no word is offered
`timescale 1ns/1ps
module vec_table_model (
    input wire logic core_clk,
    input wire logic [3:0] latency,
    input wire logic vecReq,
    input wire logic [15:0] vecAddr,
    output logic [15:0] vecData,
    output logic vecValid
);
    int cnt = 0;
    initial begin
        vecValid = 1'b0;
        vecData = 16'h0000;
    end
    // stored entry is a known function of its own address
    always @(posedge core_clk) begin
        vecValid <= 1'b0;
        vecData <= ~vecData;
        if (vecReq && !vecValid) begin
            cnt <= cnt + 1;
            if (cnt >= int'(latency)) begin
                vecValid <= 1'b1;
                vecData <= {vecAddr[7:0], 8'h5A};
                cnt <= 0;
            end
        end
    end
endmodule
